// >>> inc/fsr_pkg.sv
// Package for the flash suspend/resume sequencer and read configuration
package fsr_pkg;

	// Command codes
	localparam logic [7:0] FSR_CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] FSR_CMD_READ_ID      = 8'h90;
	localparam logic [7:0] FSR_CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] FSR_CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] FSR_CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] FSR_CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] FSR_CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] FSR_CMD_PROG_ALT     = 8'h10;
	localparam logic [7:0] FSR_CMD_SUSPEND      = 8'hB0;
	localparam logic [7:0] FSR_CMD_CONFIG_SETUP = 8'h60;
	localparam logic [7:0] FSR_CMD_CONFIG_SET   = 8'h03;

	// Status bit positions
	localparam int FSR_SR_READY     = 7;
	localparam int FSR_SR_ERASE_SUS = 6;
	localparam int FSR_SR_ERASE_ERR = 5;
	localparam int FSR_SR_PROG_ERR  = 4;
	localparam int FSR_SR_PROG_SUS  = 2;

	// Read configuration field positions
	localparam int FSR_RC_MODE  = 15;
	localparam int FSR_RC_LAT_H = 13;
	localparam int FSR_RC_LAT_L = 11;
	localparam int FSR_RC_HOLD  = 9;
	localparam int FSR_RC_WAIT  = 8;
	localparam int FSR_RC_ORDER = 7;
	localparam int FSR_RC_EDGE  = 6;
	localparam int FSR_RC_BL_H  = 2;

	// Reset value: page mode, latency code 2, four words
	localparam logic [15:0] FSR_RC_RESET    = 16'h9001;
	localparam logic [15:0] FSR_RC_WMASK    = 16'hBBC7;
	localparam logic [2:0]  FSR_LAT_RESVD   = 3'h1;
	localparam logic [2:0]  FSR_BL_FOUR     = 3'h1;
	localparam logic [2:0]  FSR_BL_EIGHT    = 3'h2;
	localparam logic [2:0]  FSR_BL_CONT     = 3'h7;
	localparam logic [15:0] FSR_ERASE_TICKS = 16'h0040;
	localparam logic [15:0] FSR_PROG_TICKS  = 16'h0010;
	localparam logic [3:0]  FSR_SUS_LAT     = 4'h3;

	typedef enum logic [1:0] {FSR_RD_ARRAY, FSR_RD_STATUS, FSR_RD_ID} fsr_read_t;

	// Decoded read configuration
	typedef struct packed {
		logic       read_mode_select;
		logic [2:0] latency_code;
		logic       output_hold_select;
		logic       wait_timing_select;
		logic       burst_order_select;
		logic       clock_edge_select;
		logic [3:0] burst_words;
		logic       burst_continuous;
	} fsr_cfg_t;

	// Command write from the host bus
	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
		logic [15:0] addr;
		logic [3:0]  block;
	} fsr_cmd_t;

endpackage : fsr_pkg

// >>> logic/fsr_sequencer.sv
// Command sequencer with erase/program suspend-resume and read configuration register
`timescale 1ns/1ps

module fsr_sequencer
	import fsr_pkg::*;
#(
	parameter logic [15:0] ERASE_TICKS = FSR_ERASE_TICKS,
	parameter logic [15:0] PROG_TICKS  = FSR_PROG_TICKS
)(
	// Clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst_n,
	// Command write port
	input  wire fsr_cmd_t  cmd_in,
	// Read access
	input  wire logic [3:0] rd_block,
	input  wire logic       rd_main_block,
	// Status and mode
	output fsr_read_t      read_source,
	output logic [7:0]     status_reg,
	output logic           array_read_ok,
	output logic           burst_read_en,
	output logic [15:0]    read_config_reg,
	output fsr_cfg_t       read_cfg,
	output logic [3:0]     erase_block,
	output logic [3:0]     prog_block
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ERASE_CONF, ST_PROG_DATA, ST_CFG_DATA,
		ST_ERASE, ST_ERASE_SUSING, ST_ERASE_SUS,
		ST_PROG, ST_PROG_SUSING, ST_PROG_SUS
	} fsr_state_t;

	logic rst_s1_r;
	logic rst_sync_n;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1_r   <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	fsr_state_t  state_r, state_nxt;
	logic        nested_r, nested_nxt;
	logic        in_esus_r, in_esus_nxt;
	logic [15:0] erase_cnt_r, erase_cnt_nxt;
	logic [15:0] prog_cnt_r, prog_cnt_nxt;
	logic [3:0]  lat_r, lat_nxt;
	logic [3:0]  eblk_r, eblk_nxt;
	logic [3:0]  pblk_r, pblk_nxt;
	logic [1:0]  err_r, err_nxt;
	logic [15:0] rcr_r, rcr_nxt;
	fsr_read_t   src_r, src_nxt;
	logic        aok_r, aok_nxt;

	function automatic logic is_prog_setup(input logic [7:0] d);
		is_prog_setup = (d == FSR_CMD_PROG_SETUP) || (d == FSR_CMD_PROG_ALT);
	endfunction : is_prog_setup

	function automatic logic [3:0] burst_words(input logic [15:0] rc);
		if (rc[FSR_RC_MODE] || rc[FSR_RC_BL_H:0] == FSR_BL_FOUR)
			burst_words = 4'h4;
		else if (rc[FSR_RC_BL_H:0] == FSR_BL_EIGHT)
			burst_words = 4'h8;
		else
			burst_words = 4'h0;
	endfunction : burst_words

	function automatic fsr_cfg_t decode_cfg(input logic [15:0] rc);
		fsr_cfg_t d;
		d.read_mode_select   = rc[FSR_RC_MODE];
		d.latency_code       = rc[FSR_RC_LAT_H:FSR_RC_LAT_L];
		d.output_hold_select = rc[FSR_RC_HOLD];
		d.wait_timing_select = rc[FSR_RC_WAIT];
		d.burst_order_select = rc[FSR_RC_ORDER];
		d.clock_edge_select  = rc[FSR_RC_EDGE];
		d.burst_words        = burst_words(rc);
		d.burst_continuous   = !rc[FSR_RC_MODE] && rc[FSR_RC_BL_H:0] == FSR_BL_CONT;
		decode_cfg = d;
	endfunction : decode_cfg

	// Decoded fields are registered as well, so the struct output comes from flops
	localparam fsr_cfg_t CFG_RESET = decode_cfg(FSR_RC_RESET);

	logic c_valid;
	logic [7:0] c_data;
	assign c_valid = cmd_in.valid;
	assign c_data  = cmd_in.data;

	always_comb
	begin
		state_nxt     = state_r;
		nested_nxt    = nested_r;
		in_esus_nxt   = in_esus_r;
		erase_cnt_nxt = erase_cnt_r;
		prog_cnt_nxt  = prog_cnt_r;
		lat_nxt       = lat_r;
		eblk_nxt      = eblk_r;
		pblk_nxt      = pblk_r;
		err_nxt       = err_r;
		rcr_nxt       = rcr_r;
		src_nxt       = src_r;
		unique case (state_r)
			ST_IDLE:
			begin
				if (c_valid)
				begin
					if (in_esus_r)
					begin
						// Erase-suspend command set
						if (c_data == FSR_CMD_READ_ARRAY)
							src_nxt = FSR_RD_ARRAY;
						else if (c_data == FSR_CMD_READ_STATUS)
							src_nxt = FSR_RD_STATUS;
						else if (is_prog_setup(c_data))
							state_nxt = ST_PROG_DATA;
						else if (c_data == FSR_CMD_CONFIRM)
						begin
							// Resume clears suspended and ready bits
							in_esus_nxt = 1'b0;
							lat_nxt     = 4'h0;
							state_nxt   = ST_ERASE;
							src_nxt     = FSR_RD_STATUS;
						end
						else if (c_data != FSR_CMD_SUSPEND)
						begin
							// Improper sequence, erase stays suspended
							err_nxt = 2'b11;
							src_nxt = FSR_RD_STATUS;
						end
					end
					else if (c_data == FSR_CMD_READ_ARRAY)
						src_nxt = FSR_RD_ARRAY;
					else if (c_data == FSR_CMD_READ_STATUS)
						src_nxt = FSR_RD_STATUS;
					else if (c_data == FSR_CMD_READ_ID)
						src_nxt = FSR_RD_ID;
					else if (c_data == FSR_CMD_CLEAR_STATUS)
					begin
						err_nxt = 2'b00;
						src_nxt = FSR_RD_ARRAY;
					end
					else if (c_data == FSR_CMD_ERASE_SETUP)
						state_nxt = ST_ERASE_CONF;
					else if (is_prog_setup(c_data))
						state_nxt = ST_PROG_DATA;
					else if (c_data == FSR_CMD_CONFIG_SETUP)
						state_nxt = ST_CFG_DATA;
				end
			end
			ST_ERASE_CONF:
			begin
				if (c_valid)
				begin
					src_nxt = FSR_RD_STATUS;
					if (c_data == FSR_CMD_CONFIRM)
					begin
						eblk_nxt      = cmd_in.block;
						erase_cnt_nxt = ERASE_TICKS;
						state_nxt     = ST_ERASE;
					end
					else
					begin
						err_nxt   = 2'b11;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_PROG_DATA:
			begin
				if (c_valid)
				begin
					src_nxt = FSR_RD_STATUS;
					if (in_esus_r && cmd_in.block == eblk_r)
					begin
						// Program into the suspended block is refused
						err_nxt   = 2'b11;
						state_nxt = ST_IDLE;
					end
					else
					begin
						pblk_nxt     = cmd_in.block;
						prog_cnt_nxt = PROG_TICKS;
						nested_nxt   = in_esus_r;
						state_nxt    = ST_PROG;
					end
				end
			end
			ST_CFG_DATA:
			begin
				if (c_valid)
				begin
					if (c_data == FSR_CMD_CONFIG_SET)
						rcr_nxt = cmd_in.addr & FSR_RC_WMASK;
					else
						err_nxt = 2'b11;
					src_nxt   = FSR_RD_ARRAY;
					state_nxt = ST_IDLE;
				end
			end
			ST_ERASE:
			begin
				if (c_valid && c_data == FSR_CMD_SUSPEND)
				begin
					lat_nxt   = FSR_SUS_LAT;
					state_nxt = ST_ERASE_SUSING;
					src_nxt   = FSR_RD_STATUS;
				end
				else if (erase_cnt_r == 16'h0000)
					state_nxt = ST_IDLE;
				else
					erase_cnt_nxt = erase_cnt_r - 16'h0001;
			end
			ST_ERASE_SUSING:
			begin
				if (lat_r == 4'h0)
				begin
					in_esus_nxt = 1'b1;
					state_nxt   = ST_IDLE;
				end
				else
					lat_nxt = lat_r - 4'h1;
			end
			ST_PROG:
			begin
				if (c_valid && c_data == FSR_CMD_SUSPEND)
				begin
					lat_nxt   = FSR_SUS_LAT;
					state_nxt = ST_PROG_SUSING;
					src_nxt   = FSR_RD_STATUS;
				end
				else if (prog_cnt_r == 16'h0000)
				begin
					nested_nxt = 1'b0;
					state_nxt  = ST_IDLE; // back to erase suspend if nested
				end
				else
					prog_cnt_nxt = prog_cnt_r - 16'h0001;
			end
			ST_PROG_SUSING:
			begin
				if (lat_r == 4'h0)
					state_nxt = ST_PROG_SUS;
				else
					lat_nxt = lat_r - 4'h1;
			end
			ST_PROG_SUS:
			begin
				if (c_valid)
				begin
					// Program-suspend command set
					if (c_data == FSR_CMD_READ_ARRAY)
						src_nxt = FSR_RD_ARRAY;
					else if (c_data == FSR_CMD_READ_STATUS)
						src_nxt = FSR_RD_STATUS;
					else if (c_data == FSR_CMD_CONFIRM)
					begin
						state_nxt = ST_PROG;
						src_nxt   = FSR_RD_STATUS;
					end
					else
					begin
						err_nxt = 2'b11;
						src_nxt = FSR_RD_STATUS;
					end
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Outputs are derived from next state so they stay registered
	logic [7:0] sr_nxt;
	logic       busy_nxt;
	logic       burst_nxt;
	fsr_cfg_t   cfg_nxt;
	always_comb
	begin
		busy_nxt = (state_nxt == ST_ERASE) || (state_nxt == ST_ERASE_SUSING) ||
		           (state_nxt == ST_PROG) || (state_nxt == ST_PROG_SUSING);
		sr_nxt = 8'h00;
		sr_nxt[FSR_SR_READY]     = !busy_nxt;
		sr_nxt[FSR_SR_ERASE_SUS] = in_esus_nxt;
		sr_nxt[FSR_SR_PROG_SUS]  = (state_nxt == ST_PROG_SUS);
		sr_nxt[FSR_SR_ERASE_ERR] = err_nxt[1];
		sr_nxt[FSR_SR_PROG_ERR]  = err_nxt[0];
		// Suspended block is excluded from array reads
		aok_nxt = (src_nxt == FSR_RD_ARRAY) && !busy_nxt &&
		          !(in_esus_nxt && rd_block == eblk_nxt) &&
		          !((state_nxt == ST_PROG_SUS) && rd_block == pblk_nxt);
		// Burst only for main-block array reads
		burst_nxt = !rcr_nxt[FSR_RC_MODE] && aok_nxt && rd_main_block;
		cfg_nxt   = decode_cfg(rcr_nxt);
	end

	logic [7:0] sr_r;
	logic       burst_r;
	fsr_cfg_t   cfg_r;
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_r     <= ST_IDLE;
			nested_r    <= 1'b0;
			in_esus_r   <= 1'b0;
			erase_cnt_r <= 16'h0000;
			prog_cnt_r  <= 16'h0000;
			lat_r       <= 4'h0;
			eblk_r      <= 4'h0;
			pblk_r      <= 4'h0;
			err_r       <= 2'b00;
			rcr_r       <= FSR_RC_RESET;
			src_r       <= FSR_RD_ARRAY;
			aok_r       <= 1'b0;
			sr_r        <= 8'h80;
			burst_r     <= 1'b0;
			cfg_r       <= CFG_RESET;
		end
		else
		begin
			state_r     <= state_nxt;
			nested_r    <= nested_nxt;
			in_esus_r   <= in_esus_nxt;
			erase_cnt_r <= erase_cnt_nxt;
			prog_cnt_r  <= prog_cnt_nxt;
			lat_r       <= lat_nxt;
			eblk_r      <= eblk_nxt;
			pblk_r      <= pblk_nxt;
			err_r       <= err_nxt;
			rcr_r       <= rcr_nxt;
			src_r       <= src_nxt;
			aok_r       <= aok_nxt;
			sr_r        <= sr_nxt;
			burst_r     <= burst_nxt;
			cfg_r       <= cfg_nxt;
		end
	end

	assign read_source     = src_r;
	assign status_reg      = sr_r;
	assign array_read_ok   = aok_r;
	assign burst_read_en   = burst_r;
	assign read_config_reg = rcr_r;
	assign erase_block     = eblk_r;
	assign prog_block      = pblk_r;
	assign read_cfg        = cfg_r;

	a_erase_sus_flags: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_ERASE_SUSING && lat_r == 4'h0) |=> (sr_r[7] && sr_r[6]))
		else $error("erase suspend flags not set");
	a_erase_resume: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_IDLE && in_esus_r && c_valid && c_data == FSR_CMD_CONFIRM)
		|=> (!sr_r[7] && !sr_r[6] && src_r == FSR_RD_STATUS))
		else $error("erase resume wrong");
	a_prog_sus_flags: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_PROG_SUS) |-> (sr_r[7] && sr_r[2]))
		else $error("program suspend flags wrong");
	a_prog_resume: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_PROG_SUS && c_valid && c_data == FSR_CMD_CONFIRM) |=> (!sr_r[7] && !sr_r[2]))
		else $error("program resume wrong");
	a_esus_sticky: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(in_esus_r && !(state_r == ST_IDLE && c_valid && c_data == FSR_CMD_CONFIRM)) |=> in_esus_r)
		else $error("erase suspend dropped");
	a_nested_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		nested_r |-> (state_r != ST_ERASE && state_r != ST_ERASE_SUSING))
		else $error("erase resumed during program");
	a_status_after: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_ERASE && c_valid && c_data == FSR_CMD_SUSPEND) |=> (src_r == FSR_RD_STATUS) [*3])
		else $error("status not shown");
	a_burst_main: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		burst_r |-> (src_r == FSR_RD_ARRAY && !rcr_r[FSR_RC_MODE]))
		else $error("burst on wrong read");
	a_ready_busy: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(state_r == ST_ERASE || state_r == ST_PROG) |-> !sr_r[7])
		else $error("ready while busy");

	c_nested: cover property (@(posedge core_clk) nested_r && state_r == ST_PROG_SUS);
	c_erase_sus: cover property (@(posedge core_clk) state_r == ST_IDLE && in_esus_r);
	c_cfg_write: cover property (@(posedge core_clk) state_r == ST_CFG_DATA && c_valid);

endmodule : fsr_sequencer

// >>> testbench/fsr_host_model.sv
// Host bus model issuing command writes and read selections to the sequencer
`timescale 1ns/1ps

module fsr_host_model
	import fsr_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Command and read drive
	output fsr_cmd_t        cmd_in,
	output logic [3:0]      rd_block,
	output logic            rd_main_block
);
	// No write-protect pin here; host level is held by construction
	initial
	begin
		cmd_in        = '0;
		rd_block      = 4'h0;
		rd_main_block = 1'b0;
	end

	// Callers give only legal codes and zeroed reserved config bits
	// One idle edge between writes so valid is never driven twice per step
	task automatic write_cmd(input logic [7:0] data, input logic [15:0] addr, input logic [3:0] blk);
		@(posedge core_clk);
		cmd_in <= '{valid: 1'b1, data: data, addr: addr, block: blk};
		@(posedge core_clk);
		cmd_in <= '{valid: 1'b0, data: ~data, addr: ~addr, block: ~blk};
	endtask : write_cmd

	task automatic set_read(input logic [3:0] blk, input logic main);
		@(posedge core_clk);
		rd_block      <= blk;
		rd_main_block <= main;
	endtask : set_read
endmodule : fsr_host_model

// >>> testbench/fsr_sequencer_tb.sv
// Self-checking testbench for the suspend/resume sequencer and read configuration
`timescale 1ns/1ps

module fsr_sequencer_tb
	import fsr_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	fsr_cmd_t    cmd_in;
	logic [3:0]  rd_block;
	logic        rd_main_block;
	fsr_read_t   read_source;
	logic [7:0]  status_reg;
	logic        array_read_ok;
	logic        burst_read_en;
	logic [15:0] read_config_reg;
	fsr_cfg_t    read_cfg;
	logic [3:0]  erase_block;
	logic [3:0]  prog_block;
	int          n_mismatch;
	int          compares;
	int          cyc;
	logic [15:0] cfg_tab [3];

	fsr_host_model HOST (
		.core_clk      (core_clk),
		.cmd_in        (cmd_in),
		.rd_block      (rd_block),
		.rd_main_block (rd_main_block)
	);

	fsr_sequencer DUT (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.cmd_in          (cmd_in),
		.rd_block        (rd_block),
		.rd_main_block   (rd_main_block),
		.read_source     (read_source),
		.status_reg      (status_reg),
		.array_read_ok   (array_read_ok),
		.burst_read_en   (burst_read_en),
		.read_config_reg (read_config_reg),
		.read_cfg        (read_cfg),
		.erase_block     (erase_block),
		.prog_block      (prog_block)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [7:0] d, input logic [3:0] b);
		HOST.write_cmd(d, 16'h0000, b);
		settle();
	endtask : wr

	// Bounded poll on the ready bit
	task automatic wait_ready(input int lim);
		int i;
		for (i = 0; i < lim && status_reg[FSR_SR_READY] !== 1'b1; i++)
			@(posedge core_clk);
		#1;
	endtask : wait_ready

	task automatic chk_src(input fsr_read_t s);
		chk({14'h0000, read_source}, {14'h0000, s});
	endtask : chk_src

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	initial
	begin
		logic [15:0] v;
		n_mismatch = 0;
		compares   = 0;
		cyc        = 0;
		rst_n      = 1'b0;
		cfg_tab    = '{16'h33C7, 16'h1002, 16'h9002};
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk({8'h00, status_reg}, 16'h0080);
		chk_src(FSR_RD_ARRAY);
		chk(read_config_reg, 16'h9001);
		chk({13'h0000, read_cfg.latency_code}, 16'h0002);
		chk({12'h000, read_cfg.burst_words}, 16'h0004);

		// Three register values across the fields, burst and page mode
		foreach (cfg_tab[k])
		begin
			v = cfg_tab[k];
			HOST.write_cmd(FSR_CMD_CONFIG_SETUP, 16'h0000, 4'h0);
			HOST.write_cmd(FSR_CMD_CONFIG_SET, v, 4'h0);
			HOST.set_read(4'h1, 1'b1);
			settle();
			chk(read_config_reg, v);
			chk({15'h0000, read_cfg.read_mode_select}, {15'h0000, v[15]});
			chk({13'h0000, read_cfg.latency_code}, {13'h0000, v[13:11]});
			chk({15'h0000, read_cfg.output_hold_select}, {15'h0000, v[9]});
			chk({15'h0000, read_cfg.wait_timing_select}, {15'h0000, v[8]});
			chk({15'h0000, read_cfg.burst_order_select}, {15'h0000, v[7]});
			chk({15'h0000, read_cfg.clock_edge_select}, {15'h0000, v[6]});
			chk({15'h0000, read_cfg.burst_continuous}, {15'h0000, !v[15] && v[2:0] == 3'h7});
			if (v[15] || v[2:0] != 3'h7)
				chk({12'h000, read_cfg.burst_words}, (!v[15] && v[2:0] == 3'h2) ? 16'h0008 : 16'h0004);
			chk({15'h0000, burst_read_en}, {15'h0000, !v[15]});
			wr(FSR_CMD_READ_STATUS, 4'h0);
			chk({15'h0000, burst_read_en}, 16'h0000);
			HOST.set_read(4'h1, 1'b0);
			settle();
			chk({15'h0000, burst_read_en}, 16'h0000);
		end

		// Erase, suspend, reads around the suspended block
		HOST.write_cmd(FSR_CMD_ERASE_SETUP, 16'h0000, 4'h0);
		wr(FSR_CMD_CONFIRM, 4'h3);
		chk({8'h00, status_reg}, 16'h0000);
		chk({12'h000, erase_block}, 16'h0003);
		HOST.write_cmd(FSR_CMD_SUSPEND, 16'h0000, 4'h0);
		wait_ready(20);
		chk({8'h00, status_reg}, 16'h00C0);
		chk_src(FSR_RD_STATUS);
		wr(FSR_CMD_READ_ARRAY, 4'h0);
		chk_src(FSR_RD_ARRAY);
		HOST.set_read(4'h3, 1'b1);
		settle();
		chk({15'h0000, array_read_ok}, 16'h0000);
		HOST.set_read(4'h5, 1'b1);
		settle();
		chk({15'h0000, array_read_ok}, 16'h0001);
		wr(FSR_CMD_READ_STATUS, 4'h0);
		chk_src(FSR_RD_STATUS);

		// Nested program, then its suspension
		HOST.write_cmd(FSR_CMD_PROG_ALT, 16'h0000, 4'h0);
		wr(8'hA5, 4'h5);
		chk({8'h00, status_reg}, 16'h0040);
		chk({12'h000, prog_block}, 16'h0005);
		HOST.write_cmd(FSR_CMD_SUSPEND, 16'h0000, 4'h0);
		wait_ready(20);
		chk({8'h00, status_reg}, 16'h00C4);
		chk_src(FSR_RD_STATUS);
		wr(FSR_CMD_READ_ARRAY, 4'h0);
		settle();
		chk({15'h0000, array_read_ok}, 16'h0000);
		HOST.set_read(4'h7, 1'b1);
		settle();
		chk({15'h0000, array_read_ok}, 16'h0001);

		// Improper command keeps the suspension, flags both error bits
		wr(FSR_CMD_ERASE_SETUP, 4'h0);
		chk({8'h00, status_reg}, 16'h00F4);
		chk_src(FSR_RD_STATUS);

		// Program resume, early erase resume ignored while busy
		wr(FSR_CMD_CONFIRM, 4'h5);
		chk({8'h00, status_reg}, 16'h0070);
		chk_src(FSR_RD_STATUS);
		HOST.write_cmd(FSR_CMD_CONFIRM, 16'h0000, 4'h3);
		wait_ready(60);
		chk({8'h00, status_reg}, 16'h00F0);
		// Program aimed at the suspended block is refused
		HOST.write_cmd(FSR_CMD_PROG_SETUP, 16'h0000, 4'h0);
		wr(8'h5A, 4'h3);
		chk({8'h00, status_reg}, 16'h00F0);
		chk({12'h000, prog_block}, 16'h0005);
		wr(FSR_CMD_CONFIRM, 4'h3);
		chk({8'h00, status_reg}, 16'h0030);
		chk_src(FSR_RD_STATUS);
		wait_ready(200);
		chk({8'h00, status_reg}, 16'h00B0);

		// Clear errors, then a plain program with suspend and resume
		wr(FSR_CMD_CLEAR_STATUS, 4'h0);
		chk({8'h00, status_reg}, 16'h0080);
		HOST.write_cmd(FSR_CMD_PROG_SETUP, 16'h0000, 4'h0);
		wr(8'h5A, 4'h2);
		chk({12'h000, prog_block}, 16'h0002);
		HOST.write_cmd(FSR_CMD_SUSPEND, 16'h0000, 4'h0);
		wait_ready(20);
		chk({8'h00, status_reg}, 16'h0084);
		wr(FSR_CMD_READ_ARRAY, 4'h0);
		HOST.set_read(4'h2, 1'b1);
		settle();
		chk({15'h0000, array_read_ok}, 16'h0000);
		wr(FSR_CMD_CONFIRM, 4'h2);
		chk({8'h00, status_reg}, 16'h0000);
		wait_ready(40);
		chk({8'h00, status_reg}, 16'h0080);
		wr(FSR_CMD_READ_ID, 4'h0);
		chk_src(FSR_RD_ID);
		chk({15'h0000, burst_read_en}, 16'h0000);
		end_sim();
	end
endmodule : fsr_sequencer_tb
